// ### acr_bank.v
/*
 Control and status register bank of the amplifier, its I2C
 slave, interrupt pin, and serial audio receive/transmit path.
 Assumes pins arrive asynchronous to CLOCK and are far slower.
*/
`timescale 1ns/1ns
`include "acr_map.vh"
module acr_bank #(
    parameter [15:0] ID_CODE = 16'hA5C3, // arbitrary value
    parameter        DW      = 32
) (
    input  wire          CLOCK,
    input  wire          RST,
    input  wire          SCL,
    input  wire          SDA_IN,
    output reg           SDA_OUT,
    output reg           SDA_OE,
    input  wire [1:0]    AD_SEL,
    input  wire [15:0]   STATUS,
    input  wire [9:0]    VBAT_IN,
    input  wire [9:0]    TEMP_IN,
    input  wire [9:0]    BOOST_RAIL_READING_IN,
    input  wire          BCK,
    input  wire          FRAME_SYNC_PIN,
    input  wire          DATAI,
    input  wire [DW-1:0] TX_WORD,
    output reg           DATAO,
    output reg           DATAO_OE,
    output reg           IRQ_OUT_PIN,
    output reg           IRQ_OE,
    output reg  [DW-1:0] SAMPLE_DATA,
    output reg           SAMPLE_VALID,
    input  wire          SAMPLE_READY,
    output reg           RX_OVERRUN,
    output reg           PLL_REF,
    output wire          SYSTEM_SLEEP,
    output wire          AMPLIFIER_SLEEP,
    output wire          EARPIECE_SELECT,
    output wire          LIMITER_ENABLE,
    output wire          LIMITER_DETECT_KIND,
    output wire [3:0]    RATE_CODE,
    output reg  [9:0]    ATTEN_EIGHTHS
);
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_DEV  = 5'h02;
localparam [4:0] ST_REG  = 5'h04;
localparam [4:0] ST_WR   = 5'h08;
localparam [4:0] ST_RD   = 5'h10;

reg  [6:0]  s1, s2, s3;
reg  [15:0] masks, sys, sys2, sac, slot, oset;
reg  [15:0] lth, atk, rel, bst, flags, st_q;
reg  [9:0]  vbat, temp, boost_rail_reading;
reg  [4:0]  st;
reg  [3:0]  cnt;
reg  [7:0]  sh, ob, ptr, waddr, hi;
reg  [15:0] rdw, wdat, rdata;
reg         wr_en, rd_clr, mack, half;

// ------------------------------------------------------------
// Pin synchronisers
// ------------------------------------------------------------
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        s1 <= 7'h00;
        s2 <= 7'h00;
        s3 <= 7'h00;
    end else begin
        s1 <= {AD_SEL, DATAI, FRAME_SYNC_PIN, BCK, SDA_IN, SCL};
        s2 <= s1;
        s3 <= s2;
    end
end

wire scl_rise = s2[0] & ~s3[0];
wire scl_fall = ~s2[0] & s3[0];
wire i2c_start = s2[0] & s3[0] & s3[1] & ~s2[1];
wire i2c_stop  = s2[0] & s3[0] & ~s3[1] & s2[1];
wire [2:0] nb  = 3'd6 - cnt[2:0];

// ------------------------------------------------------------
// I2C slave
// ------------------------------------------------------------
// byte framing
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        st <= ST_IDLE;
        cnt <= 4'h0;
        sh <= 8'h00;
        ob <= 8'h00;
        ptr <= 8'h00;
        waddr <= 8'h00;
        hi <= 8'h00;
        rdw <= 16'h0000;
        wdat <= 16'h0000;
        wr_en <= 1'b0;
        rd_clr <= 1'b0;
        mack <= 1'b0;
        half <= 1'b0;
        SDA_OE <= 1'b0;
        SDA_OUT <= 1'b0;
    end else begin
        wr_en <= 1'b0;
        rd_clr <= 1'b0;
        if (i2c_start) begin
            st <= ST_DEV;
            // SCL fall that ends the start must not count as a bit
            cnt <= 4'hF;
            half <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (i2c_stop) begin
            st <= ST_IDLE;
            SDA_OE <= 1'b0;
        end else if (scl_rise) begin
            if (cnt != 4'd8)
                sh <= {sh[6:0], s2[1]};
            else
                mack <= ~s2[1];
        end else if (scl_fall && cnt != 4'd8) begin
            cnt <= cnt + 4'd1;
            if (cnt == 4'd7) begin
                case (st)
                    ST_DEV: begin
                        if (sh[7:1] == {`ACR_DEV_BASE, s2[6:5]}) begin
                            SDA_OE <= 1'b1;
                            st <= sh[0] ? ST_RD : ST_REG;
                        end else
                            st <= ST_IDLE;
                    end
                    ST_REG: begin
                        ptr <= sh;
                        SDA_OE <= 1'b1;
                        st <= ST_WR;
                    end
                    ST_WR: begin
                        SDA_OE <= 1'b1;
                        half <= ~half;
                        if (!half)
                            hi <= sh;
                        else begin
                            wr_en <= 1'b1;
                            waddr <= ptr;
                            wdat <= {hi, sh};
                            ptr <= ptr + 8'd1;
                        end
                    end
                    default: SDA_OE <= 1'b0;
                endcase
            end else if (st == ST_RD)
                SDA_OE <= ~ob[nb];
        end else if (scl_fall) begin
            cnt <= 4'h0;
            SDA_OE <= 1'b0;
            if (st == ST_RD && !mack)
                st <= ST_IDLE;
            else if (st == ST_RD) begin
                half <= ~half;
                if (!half) begin
                    rdw <= rdata;
                    ob <= rdata[15:8];
                    SDA_OE <= ~rdata[15];
                    rd_clr <= (ptr == `ACR_REG_FLAGS);
                end else begin
                    ob <= rdw[7:0];
                    SDA_OE <= ~rdw[7];
                    ptr <= ptr + 8'd1;
                end
            end
        end
    end
end

always @* begin
    case (ptr)
        `ACR_REG_ID:    rdata = ID_CODE;
        8'h01:          rdata = STATUS & `ACR_EVT_USED;
        `ACR_REG_FLAGS: rdata = flags;
        `ACR_REG_MASKS: rdata = masks;
        `ACR_REG_SYS:   rdata = sys;
        `ACR_REG_SYS2:  rdata = sys2;
        `ACR_REG_SAC:   rdata = sac;
        `ACR_REG_SLOT:  rdata = slot;
        `ACR_REG_OSET:  rdata = oset;
        `ACR_REG_LTH:   rdata = lth;
        `ACR_REG_ATK:   rdata = atk;
        `ACR_REG_REL:   rdata = rel;
        `ACR_REG_VBAT:  rdata = {6'h00, vbat};
        `ACR_REG_TEMP:  rdata = {6'h00, temp};
        `ACR_REG_BOOST_RAIL_READING:  rdata = {6'h00, boost_rail_reading};
        `ACR_REG_BST:   rdata = bst;
        default:        rdata = 16'h0000;
    endcase
end

// ------------------------------------------------------------
// Configuration registers
// ------------------------------------------------------------
task load_defaults;
    begin
        masks <= `ACR_RST_MASKS;
        sys <= `ACR_RST_SYS;
        sys2 <= `ACR_RST_SYS2;
        sac <= `ACR_RST_SAC;
        slot <= `ACR_RST_SLOT;
        oset <= `ACR_RST_OSET;
        lth <= `ACR_RST_LTH;
        atk <= `ACR_RST_ATK;
        rel <= `ACR_RST_REL;
        bst <= `ACR_RST_BST;
    end
endtask

always @(posedge CLOCK or posedge RST) begin
    if (RST)
        load_defaults;
    else if (wr_en && waddr == `ACR_REG_ID && wdat == `ACR_SOFT_KEY)
        load_defaults;
    else if (wr_en) begin
        case (waddr)
            `ACR_REG_MASKS: masks <= wdat;
            `ACR_REG_SYS:   sys <= wdat;
            `ACR_REG_SYS2:  sys2 <= wdat;
            `ACR_REG_SAC:   sac <= wdat;
            `ACR_REG_SLOT:  slot <= wdat;
            `ACR_REG_OSET:  oset <= wdat;
            `ACR_REG_LTH:   lth <= wdat;
            `ACR_REG_ATK:   atk <= (wdat == 16'h0000) ? atk : wdat;
            `ACR_REG_REL:   rel <= (wdat == 16'h0000) ? rel : wdat;
            `ACR_REG_BST:   bst <= wdat;
            default: ;
        endcase
    end
end

// ------------------------------------------------------------
// Event flags, readings and interrupt pin
// ------------------------------------------------------------
// source select
wire [15:0] irq_src = sys2[`ACR_SYS2_SRC] ? STATUS : flags;
wire        irq_act = |(irq_src & ~masks & `ACR_EVT_USED);

always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        st_q <= 16'h0000;
        flags <= 16'h0000;
        vbat <= `ACR_RST_VOLT;
        temp <= `ACR_RST_TEMP;
        boost_rail_reading <= `ACR_RST_VOLT;
        IRQ_OUT_PIN <= 1'b1;
        IRQ_OE <= 1'b0;
        PLL_REF <= 1'b0;
        ATTEN_EIGHTHS <= 10'h000;
    end else begin
        st_q <= STATUS;
        // change sets flag; set beats clear
        flags <= (flags & ~(rd_clr ? rdw : 16'h0000))
               | ((STATUS ^ st_q) & `ACR_EVT_USED);
        vbat <= VBAT_IN;
        temp <= TEMP_IN;
        boost_rail_reading <= BOOST_RAIL_READING_IN;
        IRQ_OUT_PIN <= sys2[`ACR_SYS2_DRV] ? ~irq_act : 1'b0;
        IRQ_OE <= sys2[`ACR_SYS2_DRV] | irq_act;
        PLL_REF <= sys[`ACR_SYS_LREF] ? s2[3] : s2[2];
        // attenuation in eighths of a dB
        ATTEN_EIGHTHS <= {4'h0, sys2[`ACR_VOL_FINE]}
                       + {1'b0, sys2[`ACR_VOL_COARSE], 5'h00}
                       + {2'b00, sys2[`ACR_VOL_COARSE], 4'h0};
    end
end

assign SYSTEM_SLEEP        = sys[`ACR_SYS_SLEEP];
assign AMPLIFIER_SLEEP     = sys[`ACR_SYS_AMP];
assign EARPIECE_SELECT     = sys[`ACR_SYS_EAR];
assign LIMITER_ENABLE      = sys[`ACR_SYS_LEN];
assign LIMITER_DETECT_KIND = sys[`ACR_SYS_LKIND];
assign RATE_CODE           = sac[`ACR_SAC_RATE];

// ------------------------------------------------------------
// Serial audio framing
// ------------------------------------------------------------
reg  [5:0] slen, wid, off;
reg  [3:0] nsl;
reg  [5:0] bi;
reg  [3:0] sl;
reg        wprev;
reg  [31:0] rsh, lw, txw;
reg        push;
reg  [DW-1:0] pdat;
reg        skid_v;
reg  [DW-1:0] skid_d;

wire b_now = s2[2] ^ sys[`ACR_SYS_BINV];
wire b_old = s3[2] ^ sys[`ACR_SYS_BINV];
wire samp  = b_now & ~b_old;
wire launch = oset[`ACR_OSET_EDGE] ? samp : (~b_now & b_old);
wire [2:0] sc = sac[`ACR_SAC_SLOTS];
wire [1:0] pick = sac[`ACR_SAC_PICK];
wire path_ok = sys[`ACR_SYS_SAEN] & ~sys[`ACR_SYS_SLEEP];
wire rx_run = path_ok & slot[`ACR_SLOT_RXEN] & (sc < 3'd6)
            & (pick != 2'b00) & (sac[`ACR_SAC_FMT] != 2'b11)
            & (sac[`ACR_SAC_BCK] != 2'b11);
wire tx_run = path_ok & slot[`ACR_SLOT_TXEN];
// frame edge: falling for I2S, rising pulse for TDM
wire fstart = (sc == 3'd0) ? (wprev & ~s2[3]) : (~wprev & s2[3]);
wire [5:0] cb = fstart ? 6'd0 : bi;
wire [3:0] cs = fstart ? 4'd0 : sl;
wire [5:0] endb = off + wid - 6'd1;
// standard slots run one bit late, past the frame edge
wire       std_fmt = (sac[`ACR_SAC_FMT] == 2'b00);
wire [5:0] wrap    = slen - 6'd1 + {5'd0, std_fmt};
wire in_win = (cb >= off) && (cb <= endb);
wire [31:0] full = {rsh[30:0], s2[4]} << (6'd32 - wid);
// slot selectors, fixed pair in I2S
wire [3:0] lsel = (sc == 3'd0) ? 4'd0 : slot[`ACR_SLOT_LEFT];
wire [3:0] rsel = (sc == 3'd0) ? 4'd1 : slot[`ACR_SLOT_RIGHT];
wire [3:0] lt = sys[`ACR_SYS_SWAP] ? rsel : lsel;
wire [3:0] rt = sys[`ACR_SYS_SWAP] ? lsel : rsel;
wire [31:0] mono = {lw[31], lw[31:1]} + {full[31], full[31:1]};
wire [5:0] tk = bi - off;
wire tx_bit = txw[~tk[4:0]];
wire in_ready = ~skid_v;

always @* begin
    // slot length is half the declared ratio
    case (sac[`ACR_SAC_BCK])
        2'b00:   slen = 6'd16;
        2'b01:   slen = 6'd24;
        default: slen = 6'd32;
    endcase
    case (sac[`ACR_SAC_WID])
        2'b00:   wid = 6'd20 - 6'd4;
        2'b01:   wid = 6'd20;
        2'b10:   wid = 6'd24;
        default: wid = 6'd32;
    endcase
    case (sac[`ACR_SAC_FMT])
        2'b00:   off = 6'd1;
        2'b10:   off = (wid > slen) ? 6'd0 : slen - wid;
        default: off = 6'd0;
    endcase
    case (sc)
        3'd1:    nsl = 4'd1;
        3'd3:    nsl = 4'd4;
        3'd4:    nsl = 4'd6;
        3'd5:    nsl = 4'd8;
        default: nsl = 4'd2;
    endcase
end

always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        bi <= 6'd0;
        sl <= 4'd0;
        // Idle frame sync is high; avoids missing the first I2S frame
        wprev <= 1'b1;
        rsh <= 32'h00000000;
        lw <= 32'h00000000;
        txw <= 32'h00000000;
        push <= 1'b0;
        pdat <= {DW{1'b0}};
        RX_OVERRUN <= 1'b0;
        DATAO <= 1'b0;
        DATAO_OE <= 1'b0;
    end else begin
        push <= 1'b0;
        if (samp) begin
            wprev <= s2[3];
            if (fstart) begin
                bi <= 6'd1;
                sl <= 4'd0;
                txw <= TX_WORD[31:0];
            end else if (bi == wrap) begin
                bi <= {5'd0, std_fmt};
                sl <= sl + 4'd1;
            end else
                bi <= bi + 6'd1;
            if (rx_run && in_win)
                rsh <= {rsh[30:0], s2[4]};
            if (rx_run && in_win && cb == endb && cs < nsl) begin
                if (cs == lt)
                    lw <= full;
                if ((cs == lt && pick == 2'b01)
                    || (cs == rt && pick[1])) begin
                    pdat <= (pick == 2'b11) ? mono : full;
                    if (in_ready)
                        push <= 1'b1;
                    else
                        RX_OVERRUN <= 1'b1;
                end
            end
        end
        if (!tx_run) begin
            DATAO_OE <= 1'b0;
        end else if (launch) begin
            if (sl == slot[`ACR_SLOT_TX] && bi >= off && bi <= endb) begin
                DATAO <= tx_bit;
                DATAO_OE <= 1'b1;
            end else begin
                DATAO <= oset[`ACR_OSET_FILL] & tx_bit;
                DATAO_OE <= ~oset[`ACR_OSET_TRI];
            end
        end
    end
end

// ------------------------------------------------------------
// Two-entry sample buffer
// ------------------------------------------------------------
// Skid entry keeps outputs straight from flops
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        SAMPLE_VALID <= 1'b0;
        SAMPLE_DATA <= {DW{1'b0}};
        skid_v <= 1'b0;
        skid_d <= {DW{1'b0}};
    end else if (SAMPLE_VALID && SAMPLE_READY) begin
        if (skid_v) begin
            SAMPLE_DATA <= skid_d;
            skid_v <= 1'b0;
        end else begin
            SAMPLE_VALID <= push;
            SAMPLE_DATA <= pdat;
        end
    end else if (push) begin
        if (!SAMPLE_VALID) begin
            SAMPLE_VALID <= 1'b1;
            SAMPLE_DATA <= pdat;
        end else begin
            skid_v <= 1'b1;
            skid_d <= pdat;
        end
    end
end

endmodule // acr_bank

// ### acr_map.vh
/*
 Register offsets, reset values and field positions of the
 amplifier control register bank. Definitions only.
*/
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
`define ACR_REG_ID      8'h00
`define ACR_REG_FLAGS   8'h02
`define ACR_REG_MASKS   8'h03
`define ACR_REG_SYS     8'h04
`define ACR_REG_SYS2    8'h05
`define ACR_REG_SAC     8'h06
`define ACR_REG_SLOT    8'h07
`define ACR_REG_OSET    8'h08
`define ACR_REG_LTH     8'h09
`define ACR_REG_ATK     8'h0A
`define ACR_REG_REL     8'h0B
`define ACR_REG_VBAT    8'h21
`define ACR_REG_TEMP    8'h22
`define ACR_REG_BOOST_RAIL_READING    8'h23
`define ACR_REG_BST     8'h60
`define ACR_DEV_BASE    5'h0D
`define ACR_SOFT_KEY    16'h55AA
`define ACR_EVT_USED    16'h6FFF
`define ACR_RST_MASKS   16'hFFFF
`define ACR_RST_SYS     16'h5307
`define ACR_RST_SYS2    16'h0009
`define ACR_RST_SAC     16'h04E8
`define ACR_RST_SLOT    16'h0102
`define ACR_RST_OSET    16'h0060
`define ACR_RST_LTH     16'h3940
`define ACR_RST_ATK     16'h0030
`define ACR_RST_REL     16'h01E0
`define ACR_RST_BST     16'h0402
`define ACR_RST_VOLT    10'h263
`define ACR_RST_TEMP    10'h019
`define ACR_SYS_SLEEP   0
`define ACR_SYS_AMP     1
`define ACR_SYS_LREF    3
`define ACR_SYS_BINV    4
`define ACR_SYS_SWAP    5
`define ACR_SYS_SAEN    6
`define ACR_SYS_EAR     7
`define ACR_SYS_LEN     10
`define ACR_SYS_LKIND   11
`define ACR_SYS2_SRC    4
`define ACR_SYS2_DRV    5
`define ACR_VOL_FINE    11:6
`define ACR_VOL_COARSE  15:12
`define ACR_SAC_RATE    3:0
`define ACR_SAC_BCK     5:4
`define ACR_SAC_WID     7:6
`define ACR_SAC_FMT     9:8
`define ACR_SAC_PICK    11:10
`define ACR_SAC_SLOTS   14:12
`define ACR_SLOT_LEFT   15:12
`define ACR_SLOT_RIGHT  11:8
`define ACR_SLOT_TX     7:4
`define ACR_SLOT_SYNCW  3
`define ACR_SLOT_RXEN   1
`define ACR_SLOT_TXEN   0
`define ACR_OSET_TRI    6
`define ACR_OSET_FILL   7
`define ACR_OSET_EDGE   8
`endif

// ### acr_bank_asserts.sv
/*
 Port checker for the amplifier register bank.
 Assumes a bind from the bench top file; one clock domain.
*/
`timescale 1ns/1ns
module acr_bank_asserts #(
    parameter DW = 32
) (
    input wire          CLOCK,
    input wire          RST,
    input wire          SDA_OUT,
    input wire          IRQ_OUT_PIN,
    input wire          IRQ_OE,
    input wire [DW-1:0] SAMPLE_DATA,
    input wire          SAMPLE_VALID,
    input wire          SAMPLE_READY,
    input wire          RX_OVERRUN,
    input wire          SYSTEM_SLEEP,
    input wire          AMPLIFIER_SLEEP,
    input wire          EARPIECE_SELECT,
    input wire          LIMITER_ENABLE,
    input wire          LIMITER_DETECT_KIND,
    input wire [3:0]    RATE_CODE
);
    // --------
    // Checks
    // --------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    a_sleep_reset: assert property (
        $fell(RST) |-> SYSTEM_SLEEP && AMPLIFIER_SLEEP
    ) else $error("sleep bits clear out of reset");
    a_mode_reset: assert property (
        $fell(RST) |->
            !EARPIECE_SELECT && !LIMITER_ENABLE && !LIMITER_DETECT_KIND
    ) else $error("mode bits set out of reset");
    a_rate_reset: assert property (
        $fell(RST) |-> RATE_CODE == 4'h8
    ) else $error("rate code not default");
    // Masks cannot be written this soon, so the pin stays quiet
    a_irq_masked: assert property (
        $fell(RST) |-> !IRQ_OE [*8]
    ) else $error("interrupt pin active while masked");
    a_od_level: assert property (
        !$past(RST) && !IRQ_OE |-> !IRQ_OUT_PIN
    ) else $error("open drain pin value not low");
    a_sda_low: assert property (
        !$past(RST) |-> !SDA_OUT
    ) else $error("data pin driven high");
    a_valid_hold: assert property (
        SAMPLE_VALID && !SAMPLE_READY |=>
            SAMPLE_VALID && $stable(SAMPLE_DATA)
    ) else $error("sample dropped before taken");
    a_overrun_stays: assert property (
        RX_OVERRUN |=> RX_OVERRUN
    ) else $error("overrun flag cleared");
endmodule // acr_bank_asserts

// ### acr_host.sv
/*
 Host model: I2C master and serial audio source.
 Assumes the bench resolves SDA from both pull enables.
*/
`timescale 1ns/1ns
module acr_host (
    input wire clk,
    input wire sda,
    output reg scl,
    output reg sda_low,
    output reg bck,
    output reg frame_sync_pin,
    output reg datai
);
    reg [7:0] junk;
    reg       jn;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        bck = 1'b0;
        frame_sync_pin = 1'b1;
        datai = 1'b0;
    end

    // --------
    // Bus cycles
    // --------
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask

    task bit_x(input b, output r);
        begin
            sda_low <= !b;
            tick(4);
            scl <= 1'b1;
            tick(4);
            r = sda;
            tick(4);
            scl <= 1'b0;
            tick(4);
        end
    endtask

    task byte_x(input [7:0] d, input a, output [7:0] q, output n);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_x(d[i], q[i]);
            bit_x(a, n);
        end
    endtask

    task start_c;
        begin
            sda_low <= 1'b0;
            tick(4);
            scl <= 1'b1;
            tick(8);
            sda_low <= 1'b1;
            tick(8);
            scl <= 1'b0;
            tick(4);
        end
    endtask

    task stop_c;
        begin
            sda_low <= 1'b1;
            tick(4);
            scl <= 1'b1;
            tick(8);
            sda_low <= 1'b0;
            tick(8);
        end
    endtask

    task write_reg(input [6:0] dev, input [7:0] ra, input [15:0] d,
                   output nak);
        reg n1, n2, n3, n4;
        begin
            start_c;
            byte_x({dev, 1'b0}, 1'b1, junk, n1);
            byte_x(ra, 1'b1, junk, n2);
            byte_x(d[15:8], 1'b1, junk, n3);
            byte_x(d[7:0], 1'b1, junk, n4);
            stop_c;
            nak = n1 | n2 | n3 | n4;
        end
    endtask

    // repeated start, ack high byte, refuse low
    task read_reg(input [6:0] dev, input [7:0] ra, output [15:0] q);
        begin
            start_c;
            byte_x({dev, 1'b0}, 1'b1, junk, jn);
            byte_x(ra, 1'b1, junk, jn);
            start_c;
            byte_x({dev, 1'b1}, 1'b1, junk, jn);
            byte_x(8'hFF, 1'b0, q[15:8], jn);
            byte_x(8'hFF, 1'b1, q[7:0], jn);
            stop_c;
        end
    endtask

    task frame(input [31:0] l, input [31:0] r);
        reg [63:0] s;
        integer    k;
        begin
            s = {l, r};
            #3;
            for (k = 0; k <= 64; k = k + 1) begin
                bck = 1'b0;
                frame_sync_pin = (k >= 32);
                datai = (k == 0) ? ~s[0] : s[64 - k];
                #80;
                bck = 1'b1;
                #80;
            end
            // Clock stops between frames; line shows a fresh level
            bck = 1'b0;
            datai = ~datai;
        end
    endtask
endmodule // acr_host

// ### acr_bank_bench.sv
/*
 Self-checking bench for the amplifier register bank.
 Assumes the host model drives the I2C and audio pins.
*/
`timescale 1ns/1ns
`include "acr_map.vh"
module acr_bank_bench;
    localparam [6:0] DEV = {`ACR_DEV_BASE, 2'b10};
    reg         clock;
    reg         rst;
    reg  [15:0] status;
    reg         ready;
    reg  [15:0] q;
    reg         nak;
    wire        scl, sda_low, sda_oe, sda_line, bck, frame_sync_pin, datai;
    wire        irq, irq_oe, svalid, ovr, ear, len, lkind;
    wire [31:0] sdata;
    wire [9:0]  atten;
    integer     num_errors;
    integer     compares;

    // Pull-up on the shared data line
    assign sda_line = !(sda_low | sda_oe);
    always #5 clock = ~clock;

    acr_bank i_dut (
        .CLOCK(clock), .RST(rst), .SCL(scl), .SDA_IN(sda_line),
        .SDA_OUT(), .SDA_OE(sda_oe), .AD_SEL(2'b10), .STATUS(status),
        .VBAT_IN(10'h2A5), .TEMP_IN(10'h019), .BOOST_RAIL_READING_IN(10'h3C1),
        .BCK(bck), .FRAME_SYNC_PIN(frame_sync_pin), .DATAI(datai), .TX_WORD(32'hC3A5_5A3C),
        .DATAO(), .DATAO_OE(), .IRQ_OUT_PIN(irq), .IRQ_OE(irq_oe),
        .SAMPLE_DATA(sdata), .SAMPLE_VALID(svalid),
        .SAMPLE_READY(ready), .RX_OVERRUN(ovr), .PLL_REF(),
        .SYSTEM_SLEEP(), .AMPLIFIER_SLEEP(), .EARPIECE_SELECT(ear),
        .LIMITER_ENABLE(len), .LIMITER_DETECT_KIND(lkind),
        .RATE_CODE(), .ATTEN_EIGHTHS(atten)
    );
    acr_host i_host (
        .clk(clock), .sda(sda_line), .scl(scl), .sda_low(sda_low),
        .bck(bck), .frame_sync_pin(frame_sync_pin), .datai(datai)
    );

    // --------
    // Helpers
    // --------
    task check(input [31:0] got, input [31:0] exp, input string what);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t %s got %h exp %h", $time, what, got,
                         exp);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("compares %0d errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task wr(input [7:0] ra, input [15:0] d);
        begin
            i_host.write_reg(DEV, ra, d, nak);
            check(nak, 1'b0, "write ack");
        end
    endtask

    task rd_chk(input [7:0] ra, input [15:0] e);
        begin
            i_host.read_reg(DEV, ra, q);
            check(q, e, "register read");
        end
    endtask

    task take(input [31:0] e);
        integer n;
        begin
            n = 0;
            while (svalid !== 1'b1 && n < 4000) begin
                @(negedge clock);
                n = n + 1;
            end
            if (n >= 4000) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t no sample", $time);
                print_verdict;
            end
            check(sdata, e, "sample");
            @(posedge clock);
            ready <= 1'b1;
            @(posedge clock);
            ready <= 1'b0;
            @(negedge clock);
        end
    endtask

    // --------
    // Scenarios
    // --------
    task t_reset_values;
        begin
            rd_chk(`ACR_REG_MASKS, 16'hFFFF);
            rd_chk(`ACR_REG_SYS, 16'h5307);
            rd_chk(`ACR_REG_SYS2, 16'h0009);
            rd_chk(`ACR_REG_SAC, 16'h04E8);
            rd_chk(`ACR_REG_SLOT, 16'h0102);
            rd_chk(`ACR_REG_OSET, 16'h0060);
            rd_chk(`ACR_REG_ATK, 16'h0030);
            rd_chk(`ACR_REG_REL, 16'h01E0);
            rd_chk(`ACR_REG_VBAT, 16'h02A5);
            rd_chk(8'h40, 16'h0000);
            $display("t_reset_values done");
        end
    endtask

    task t_writes;
        begin
            wr(`ACR_REG_SYS2, 16'h2149);
            check(atten, 10'h065, "attenuation");
            wr(`ACR_REG_SYS, 16'h5F87);
            check({lkind, len, ear}, 3'b111, "modes");
            wr(`ACR_REG_ATK, 16'h0000);
            rd_chk(`ACR_REG_ATK, 16'h0030);
            wr(`ACR_REG_VBAT, 16'h0000);
            rd_chk(`ACR_REG_VBAT, 16'h02A5);
            i_host.write_reg(DEV ^ 7'h01, `ACR_REG_SYS, 16'h0000, nak);
            check(nak, 1'b1, "foreign address");
            wr(`ACR_REG_ID, `ACR_SOFT_KEY);
            rd_chk(`ACR_REG_SYS, 16'h5307);
            check({lkind, len, ear, atten}, 13'h0000, "defaults");
            $display("t_writes done");
        end
    endtask

    task t_irq;
        begin
            @(posedge clock);
            status <= 16'h0001;
            repeat (4) @(negedge clock);
            check(irq_oe, 1'b0, "masked");
            rd_chk(`ACR_REG_FLAGS, 16'h0001);
            rd_chk(`ACR_REG_FLAGS, 16'h0000);
            wr(`ACR_REG_MASKS, 16'hFFFE);
            status <= 16'h0000;
            repeat (4) @(negedge clock);
            check({irq_oe, irq}, 2'b10, "asserted");
            rd_chk(`ACR_REG_FLAGS, 16'h0001);
            check(irq_oe, 1'b0, "released");
            wr(`ACR_REG_SYS2, 16'h0029);
            check({irq_oe, irq}, 2'b11, "push idle");
            wr(`ACR_REG_SYS2, 16'h0039);
            status <= 16'h0001;
            repeat (4) @(negedge clock);
            check({irq_oe, irq}, 2'b10, "live source");
            $display("t_irq done");
        end
    endtask

    task t_audio;
        begin
            wr(`ACR_REG_SYS, 16'h5346);
            i_host.frame(32'h8123_4567, 32'h5A5A_00FF);
            i_host.frame(32'h1357_9BDF, 32'h0000_0001);
            i_host.frame(32'hF00D_C0DE, 32'h7777_7777);
            check(ovr, 1'b1, "overrun");
            take(32'h8123_4567);
            take(32'h1357_9BDF);
            check(svalid, 1'b0, "drained");
            wr(`ACR_REG_SAC, 16'h08E8);
            i_host.frame(32'h2468_ACE0, 32'hCAFE_F00D);
            take(32'hCAFE_F00D);
            wr(`ACR_REG_SAC, 16'h0CE8);
            i_host.frame(32'h2000_0000, 32'h4000_0000);
            take(32'h3000_0000);
            wr(`ACR_REG_SAC, 16'h08E8);
            wr(`ACR_REG_SYS, 16'h5366);
            i_host.frame(32'h0F0F_0F0F, 32'h9999_6666);
            take(32'h0F0F_0F0F);
            $display("t_audio done");
        end
    endtask

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        status = 16'h0000;
        ready = 1'b0;
        num_errors = 0;
        compares = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        t_reset_values;
        t_writes;
        t_irq;
        t_audio;
        print_verdict;
    end
endmodule // acr_bank_bench

bind acr_bank acr_bank_asserts #(.DW(DW)) i_chk (
    .CLOCK(CLOCK), .RST(RST), .SDA_OUT(SDA_OUT),
    .IRQ_OUT_PIN(IRQ_OUT_PIN), .IRQ_OE(IRQ_OE),
    .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .RX_OVERRUN(RX_OVERRUN),
    .SYSTEM_SLEEP(SYSTEM_SLEEP), .AMPLIFIER_SLEEP(AMPLIFIER_SLEEP),
    .EARPIECE_SELECT(EARPIECE_SELECT), .LIMITER_ENABLE(LIMITER_ENABLE),
    .LIMITER_DETECT_KIND(LIMITER_DETECT_KIND), .RATE_CODE(RATE_CODE)
);
